// ### pkg/pif_pkg.sv
// Purpose: Shared constants of the interrupt flag and mask block
// Assumes: One 25 MHz clock, byte-wide register access
// Notes:   Offsets are byte addresses on the serial control bus
package pif_pkg;

	// Register offsets
	localparam logic [7:0] ADDR_FLAG_FIRST  = 8'h06;
	localparam logic [7:0] ADDR_FLAG_SECOND = 8'h08;
	localparam logic [7:0] ADDR_FLAG_THIRD  = 8'h09;
	localparam logic [7:0] ADDR_MASK_FIRST  = 8'h0a;

	// Field positions, second flag register
	localparam int BIT_BUCK2_THM = 1;
	localparam int BIT_BUCK3_THM = 0;

	// Field positions, third flag register
	localparam int BIT_BAT_GOOD  = 7;
	localparam int BIT_REG_DONE  = 6;
	localparam int BIT_BOOST     = 5;
	localparam int BIT_CRC_FAIL  = 3;
	localparam int BIT_BUS_TMO   = 2;
	localparam int BIT_HAPTIC    = 1;
	localparam int BIT_CONVERTER = 0;

	// Field position, first flag register
	localparam int BIT_THERMISTOR = 7;

	// Bits that software may write
	localparam logic [7:0] WMASK_FLAG_SECOND = 8'h03;
	localparam logic [7:0] WMASK_FLAG_THIRD  = 8'hec;

	// Reset values
	localparam logic [7:0] RST_FLAGS      = 8'h00;
	localparam logic [7:0] RST_MASK_FIRST = 8'h00;

	// Timing
	localparam int CLK_HZ      = 25_000_000;
	localparam int BUS_TMO_MS  = 100;
	localparam int BUS_TMO_CYC = (CLK_HZ / 1000) * BUS_TMO_MS;

endpackage

// ### src/pif_change_det.sv
// Purpose: Flags any change of a group of status levels
// Assumes: Levels synchronous to clk
// Notes:   No change reported on the first cycle after reset
`timescale 1ns/10ps
`default_nettype none
module pif_change_det #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         sys_rst,
	// Status in, change pulses out
	input  wire logic [W-1:0] level,
	output logic      [W-1:0] changed
);

	logic [W-1:0] prev_ff;
	logic         primed_ff;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prev_ff   <= '0;
			primed_ff <= 1'b0;
		end else begin
			prev_ff   <= level;
			primed_ff <= 1'b1;
		end
	end

	assign changed = primed_ff ? (level ^ prev_ff) : '0;

endmodule
`default_nettype wire

// ### src/pif_flags.sv
// Purpose: Interrupt flag and mask registers of the power manager
// Assumes: Serial front end delivers decoded byte accesses with CRC result
// Notes:   Hardware set wins over a software write in the same cycle
`timescale 1ns/10ps
`default_nettype none
module pif_flags
	import pif_pkg::*;
#(
	parameter int TMO_CYCLES = BUS_TMO_CYC,
	parameter int HPT_N      = 4,
	parameter int ADC_N      = 4
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             sys_rst,
	// Register access from serial front end
	input  wire logic             reg_wr_en,
	input  wire logic             reg_crc_ok,
	input  wire logic             reg_rd_en,
	input  wire logic [7:0]       reg_addr,
	input  wire logic [7:0]       reg_wr_data,
	output logic      [7:0]       reg_rd_data,
	// Serial bus activity
	input  wire logic             bus_start,
	input  wire logic             bus_stop,
	input  wire logic             bus_activity,
	// Status sources
	input  wire logic [2:0]       thermistor_status_field,
	input  wire logic [6:0]       first_src_status,
	input  wire logic             buck2_thermal_status,
	input  wire logic             buck3_thermal_status,
	input  wire logic             battery_good_status,
	input  wire logic             battery_regulation_done_status,
	input  wire logic             boost_fault_status,
	input  wire logic [HPT_N-1:0] haptic_src,
	input  wire logic [ADC_N-1:0] adc_src,
	// Flags and gated interrupt sources
	output logic      [7:0]       first_flags,
	output logic      [7:0]       first_flags_gated,
	output logic      [7:0]       third_flags
);

	localparam int CW = $clog2(TMO_CYCLES + 1);
	localparam logic [CW-1:0] TMO_LAST = CW'(TMO_CYCLES - 1);

	logic [7:0]    flag0_ff, flag2_ff, flag3_ff, mask0_ff;
	logic [7:0]    nxt_flag0, nxt_flag2, nxt_flag3, nxt_mask0;
	logic [7:0]    rd_data_ff, nxt_rd_data;
	logic [CW-1:0] tmo_cnt_ff, nxt_tmo_cnt;
	logic          frame_ff, nxt_frame;
	logic [2:0]    therm_chg;
	logic [6:0]    first_chg;
	logic [4:0]    misc_chg;
	logic [7:0]    set0, set2, set3;
	logic [7:0]    flag3_view;
	logic          wr_ok, wr_bad, tmo_hit;
	logic          wr_f0, wr_f2, wr_f3, wr_m0;
	logic          hpt_sum, adc_sum;

	pif_change_det #(.W(3)) u_therm (
		.clk     (clk),
		.sys_rst (sys_rst),
		.level   (thermistor_status_field),
		.changed (therm_chg)
	);

	pif_change_det #(.W(7)) u_first (
		.clk     (clk),
		.sys_rst (sys_rst),
		.level   (first_src_status),
		.changed (first_chg)
	);

	pif_change_det #(.W(5)) u_misc (
		.clk     (clk),
		.sys_rst (sys_rst),
		.level   ({buck2_thermal_status, buck3_thermal_status, battery_good_status,
		           battery_regulation_done_status, boost_fault_status}),
		.changed (misc_chg)
	);

	// Write qualification
	assign wr_ok  = reg_wr_en & reg_crc_ok;
	assign wr_bad = reg_wr_en & ~reg_crc_ok;
	assign wr_f0  = wr_ok & (reg_addr == ADDR_FLAG_FIRST);
	assign wr_f2  = wr_ok & (reg_addr == ADDR_FLAG_SECOND);
	assign wr_f3  = wr_ok & (reg_addr == ADDR_FLAG_THIRD);
	assign wr_m0  = wr_ok & (reg_addr == ADDR_MASK_FIRST);

	// Bus watchdog inside a frame
	assign tmo_hit     = frame_ff & ~bus_activity & ~bus_stop & (tmo_cnt_ff == TMO_LAST);
	assign nxt_frame   = bus_start | (frame_ff & ~bus_stop & ~tmo_hit);
	assign nxt_tmo_cnt = (bus_start | bus_activity | ~frame_ff | tmo_hit) ? '0 : tmo_cnt_ff + 1'b1;

	// Hardware set terms
	assign set0 = {|therm_chg, first_chg};
	assign set2 = {6'h00, misc_chg[4], misc_chg[3]};
	assign set3 = {misc_chg[2], misc_chg[1], misc_chg[0], 1'b0,
	               wr_bad, tmo_hit, 2'b00};

	// Set wins over a write in the same cycle
	assign nxt_flag0 = (wr_f0 ? reg_wr_data : flag0_ff) | set0;
	assign nxt_flag2 = ((wr_f2 ? reg_wr_data : flag2_ff) & WMASK_FLAG_SECOND) | set2;
	assign nxt_flag3 = ((wr_f3 ? reg_wr_data : flag3_ff) & WMASK_FLAG_THIRD) | set3;
	assign nxt_mask0 = wr_m0 ? reg_wr_data : mask0_ff;

	// Summary bits follow their sources
	assign hpt_sum    = |haptic_src;
	assign adc_sum    = |adc_src;
	assign flag3_view = {flag3_ff[7:2], hpt_sum, adc_sum};

	assign nxt_rd_data = !reg_rd_en ? rd_data_ff :
	                     (reg_addr == ADDR_FLAG_FIRST)  ? flag0_ff :
	                     (reg_addr == ADDR_FLAG_SECOND) ? flag2_ff :
	                     (reg_addr == ADDR_FLAG_THIRD)  ? flag3_view :
	                     (reg_addr == ADDR_MASK_FIRST)  ? mask0_ff : 8'h00;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			flag0_ff   <= RST_FLAGS;
			flag2_ff   <= RST_FLAGS;
			flag3_ff   <= RST_FLAGS;
			mask0_ff   <= RST_MASK_FIRST;
			rd_data_ff <= 8'h00;
			tmo_cnt_ff <= '0;
			frame_ff   <= 1'b0;
		end else begin
			flag0_ff   <= nxt_flag0;
			flag2_ff   <= nxt_flag2;
			flag3_ff   <= nxt_flag3;
			mask0_ff   <= nxt_mask0;
			rd_data_ff <= nxt_rd_data;
			tmo_cnt_ff <= nxt_tmo_cnt;
			frame_ff   <= nxt_frame;
		end
	end

	assign reg_rd_data       = rd_data_ff;
	assign first_flags       = flag0_ff;
	assign first_flags_gated = flag0_ff & mask0_ff;
	assign third_flags       = flag3_view;

	buck2_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!$past(sys_rst) && buck2_thermal_status != $past(buck2_thermal_status))
		|=> flag2_ff[BIT_BUCK2_THM])
		else $error("buck 2 thermal change not flagged");

	buck3_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!$past(sys_rst) && buck3_thermal_status != $past(buck3_thermal_status))
		|=> flag2_ff[BIT_BUCK3_THM])
		else $error("buck 3 thermal change not flagged");

	bat_good_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!$past(sys_rst) && battery_good_status != $past(battery_good_status))
		|=> third_flags[BIT_BAT_GOOD])
		else $error("battery good change not flagged");

	crc_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
		reg_wr_en && !reg_crc_ok |=> third_flags[BIT_CRC_FAIL] && $stable(mask0_ff))
		else $error("bad crc write not discarded");

	bus_tmo_a: assert property (@(posedge clk) disable iff (sys_rst)
		frame_ff && !bus_activity && !bus_stop && tmo_cnt_ff == TMO_LAST
		|=> third_flags[BIT_BUS_TMO] && !frame_ff)
		else $error("bus timeout not flagged");

	haptic_sum_a: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd_en && reg_addr == ADDR_FLAG_THIRD
		|=> reg_rd_data[BIT_HAPTIC] == $past(hpt_sum))
		else $error("haptic summary read wrong");

	adc_sum_a: assert property (@(posedge clk) disable iff (sys_rst)
		(|adc_src) |-> third_flags[BIT_CONVERTER])
		else $error("converter summary not raised");

	mask_block_a: assert property (@(posedge clk) disable iff (sys_rst)
		wr_m0 && reg_wr_data == 8'h00 |=> first_flags_gated == 8'h00)
		else $error("cleared mask passes a flag");

	mask_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
		mask0_ff[BIT_THERMISTOR] && flag0_ff[BIT_THERMISTOR] |-> first_flags_gated[BIT_THERMISTOR])
		else $error("open mask blocks thermistor flag");

	therm_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!$past(sys_rst) && thermistor_status_field != $past(thermistor_status_field))
		|=> first_flags[BIT_THERMISTOR])
		else $error("thermistor change not flagged");

	reg_done_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!$past(sys_rst) && battery_regulation_done_status != $past(battery_regulation_done_status))
		|=> third_flags[BIT_REG_DONE])
		else $error("regulation done change not flagged");

	boost_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!$past(sys_rst) && boost_fault_status != $past(boost_fault_status))
		|=> third_flags[BIT_BOOST])
		else $error("boost fault change not flagged");

	crc_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
		wr_bad |=> ((flag0_ff | $past(flag0_ff)) == flag0_ff) && ((flag2_ff | $past(flag2_ff)) == flag2_ff))
		else $error("bad crc write cleared a flag");

	stop_close_a: assert property (@(posedge clk) disable iff (sys_rst)
		frame_ff && bus_stop && !bus_start |=> !frame_ff)
		else $error("stop did not close the frame");

	mask_write_a: assert property (@(posedge clk) disable iff (sys_rst)
		wr_m0 |=> mask0_ff == $past(reg_wr_data))
		else $error("mask write not taken");

	first_chg_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!$past(sys_rst) && first_src_status[0] != $past(first_src_status[0]))
		|=> first_flags[0])
		else $error("first source change not flagged");

endmodule
`default_nettype wire

// ### tb/pif_host.sv
// Purpose: Host model issuing decoded byte accesses
// Assumes: Strobes launched and dropped just after rising edges
// Notes:   One access at a time, single bytes only
`timescale 1ns/10ps
`default_nettype none
module pif_host (
	// Clock
	input  wire logic       clk,
	// Register port
	output logic            reg_wr_en,
	output logic            reg_crc_ok,
	output logic            reg_rd_en,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wr_data,
	input  wire logic [7:0] reg_rd_data
);
	initial begin
		reg_wr_en = 1'b0;
		reg_crc_ok = 1'b1;
		reg_rd_en = 1'b0;
		reg_addr = 8'h00;
		reg_wr_data = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ok);
		@(posedge clk);
		reg_addr <= a;
		reg_wr_data <= d;
		reg_crc_ok <= ok;
		reg_wr_en <= 1'b1;
		@(posedge clk);
		reg_wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd_en <= 1'b1;
		@(posedge clk);
		reg_rd_en <= 1'b0;
		@(posedge clk);
		#1 d = reg_rd_data;
	endtask
endmodule
`default_nettype wire

// ### tb/pif_flags_bench.sv
// Purpose: Self-checking bench of the flag and mask block
// Assumes: Short watchdog of 16 cycles
// Notes:   Status levels driven by NBA on rising edges
`timescale 1ns/10ps
`default_nettype none
module pif_flags_bench;
	import pif_pkg::*;
	logic clk = 1'b0, sys_rst = 1'b1, wr_en, crc_ok, rd_en, bst = 1'b0, bsp = 1'b0, bact = 1'b0;
	logic [7:0] addr, wdata, rdata, first_flags, first_flags_gated, third_flags, d;
	logic [2:0] thm = 3'h0;
	logic [6:0] src = 7'h00;
	logic b2 = 1'b0, b3 = 1'b0, bg = 1'b0, brd = 1'b0, bf = 1'b0;
	logic [3:0] hpt = 4'h0, adc = 4'h0;
	int failures = 0, samples_checked = 0, n;
	always #20 clk = ~clk;
	pif_host pif_host_inst (.clk(clk), .reg_wr_en(wr_en), .reg_crc_ok(crc_ok), .reg_rd_en(rd_en),
		.reg_addr(addr), .reg_wr_data(wdata), .reg_rd_data(rdata));
	pif_flags #(.TMO_CYCLES(16)) pif_flags_inst (.clk(clk), .sys_rst(sys_rst), .reg_wr_en(wr_en),
		.reg_crc_ok(crc_ok), .reg_rd_en(rd_en), .reg_addr(addr), .reg_wr_data(wdata),
		.reg_rd_data(rdata), .bus_start(bst), .bus_stop(bsp), .bus_activity(bact),
		.thermistor_status_field(thm), .first_src_status(src), .buck2_thermal_status(b2),
		.buck3_thermal_status(b3), .battery_good_status(bg), .battery_regulation_done_status(brd),
		.boost_fault_status(bf), .haptic_src(hpt), .adc_src(adc), .first_flags(first_flags),
		.first_flags_gated(first_flags_gated), .third_flags(third_flags));
	task automatic wrap_up();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
			failures++;
		end
	endtask
	task automatic step(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		pif_host_inst.rd(a, d);
		chk(d, e);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		rchk(ADDR_MASK_FIRST, RST_MASK_FIRST);
		rchk(ADDR_FLAG_THIRD, RST_FLAGS);
		rchk(8'h0b, 8'h00);
		@(posedge clk);
		thm <= 3'h5;
		src <= 7'h55;
		step(3);
		chk(first_flags, 8'hd5);
		chk(first_flags_gated, 8'h00);
		pif_host_inst.wr(ADDR_MASK_FIRST, 8'h81, 1'b1);
		step(1);
		chk(first_flags_gated, 8'h81);
		pif_host_inst.wr(ADDR_MASK_FIRST, 8'h00, 1'b0);
		rchk(ADDR_MASK_FIRST, 8'h81);
		chk(third_flags, 8'h08);
		@(posedge clk);
		{b2, b3, bg, brd, bf} <= 5'h1f;
		step(3);
		rchk(ADDR_FLAG_SECOND, 8'h03);
		chk(third_flags, 8'he8);
		pif_host_inst.wr(ADDR_FLAG_THIRD, 8'h00, 1'b1);
		hpt <= 4'h8;
		adc <= 4'h1;
		step(2);
		pif_host_inst.wr(ADDR_FLAG_THIRD, 8'h00, 1'b1);
		rchk(ADDR_FLAG_THIRD, 8'h03);
		@(posedge clk);
		hpt <= 4'h0;
		step(2);
		chk(third_flags, 8'h01);
		@(posedge clk);
		bst <= 1'b1;
		@(posedge clk);
		bst <= 1'b0;
		repeat (4) begin
			repeat (8) @(posedge clk);
			bact <= 1'b1;
			@(posedge clk);
			bact <= 1'b0;
		end
		#1;
		chk(third_flags, 8'h01);
		n = 0;
		while (third_flags[2] !== 1'b1 && n < 40) begin
			step(1);
			n++;
		end
		chk(third_flags, 8'h05);
		chk(8'(n), 8'h10);
		pif_host_inst.wr(ADDR_FLAG_THIRD, 8'h00, 1'b1);
		@(posedge clk);
		bst <= 1'b1;
		@(posedge clk);
		bst <= 1'b0;
		bsp <= 1'b1;
		@(posedge clk);
		bsp <= 1'b0;
		step(20);
		chk(third_flags, 8'h01);
		wrap_up();
	end
endmodule
`default_nettype wire
